// ### logic/kch_clock_halt.sv
// Purpose: clock generation, halt control and PWM timebase selection
// Assumes: clk_i is the system clock; pin inputs are synchronous to it
// Notes:   registers sit on a classic Wishbone slave; unmapped reads return zero
//
// Added by the designer: the Wishbone register port and the register offsets.

module kch_clock_halt
	import kch_pkg::*;
#(
	parameter int unsigned HALT_UNIT_CYCLES = HALT_UNIT_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// wake sources
	input wire logic key_event_i,
	input wire logic bus_start_i,
	input wire logic encoder_change_i,
	// slow clock and crystal pins
	input wire logic ext_slow_clock_in_i,
	input wire logic crystal_in_pin_i,
	output logic crystal_out_pin_o,
	// shared output pin
	output logic buffered_timebase_out_o,
	output logic buffered_timebase_oe_n_o,
	output logic scan8_gpio3_release_o,
	// clocks and halt status to the rest of the device
	output logic execution_clock_o,
	output logic pwm_timebase_o,
	output logic halted_o
);

	import kch_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic cfg_buf_en;
		logic cfg_ext_sel;
		logic [1:0] cfg_src;
		logic [15:0] halt_time;
		logic enc_en;
		logic written;
		logic rewritten;
		logic halted;
		logic [23:0] unit_cnt;
		logic [15:0] idle_units;
		logic [3:0] exec_div;
		logic exec_clk;
		logic [4:0] pre_cnt;
		logic pre_clk;
		logic crystal_out;
		logic tb_out;
		logic tb_oe_n;
		logic pin_release;
		logic pwm_tb;
	} kch_st_s;

	kch_st_s s;
	kch_st_s next_s;

	logic sw_clk;
	logic sw_slow;
	logic slow_lvl;
	logic cmd_reset;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// applies the byte enables of a write to a stored word
	function automatic logic [31:0] wb_merge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0] be
	);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return r;
	endfunction : wb_merge

	// values after pin reset, power-on reset or the reset command
	function automatic kch_st_s st_reset();
		kch_st_s r;
		r = '0;
		r.cfg_buf_en = CFG_RST[CFG_BUF_EN_BIT];
		r.cfg_ext_sel = CFG_RST[CFG_EXT_SEL_BIT];
		r.cfg_src = CFG_RST[CFG_SRC_LSB +: 2];
		r.halt_time = HALT_TIME_RST;
		r.crystal_out = 1'b1;
		r.tb_oe_n = 1'b1;
		return r;
	endfunction : st_reset

	// ----------------------------------------------------------------
	// timebase source selection
	// ----------------------------------------------------------------
	// slow clock and crystal pins share one timebase input; the select bit says which drives it
	assign slow_lvl = s.cfg_ext_sel ? ext_slow_clock_in_i : crystal_in_pin_i;

	// the reset command must also pull the switch back, else a stuck slow pin keeps it there
	assign cmd_reset = cyc_i && stb_i && !s.ack && we_i && adr_i == ADR_CONTROL && sel_i[0] &&
		dat_i[CTRL_SRST_BIT];

	kch_tb_switch u_switch (
		.clk_i(clk_i),
		.rst_i(rst_i || cmd_reset),
		.sel_slow_i(s.cfg_src == SRC_SLOW),
		.fast_i(s.pre_clk),
		.slow_i(slow_lvl),
		.clk_o(sw_clk),
		.slow_active_o(sw_slow)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic access;
		logic wr;
		logic activity;
		logic exec_run;
		logic exec_rise;
		logic [31:0] wv;
		logic [31:0] rd;
		logic srst;
		access = cyc_i && stb_i && !s.ack;
		wr = access && we_i;
		wv = '0;
		rd = '0;
		srst = 1'b0;
		exec_rise = 1'b0;
		activity = 1'b0;
		exec_run = 1'b0;
		next_s = s;

		// bus handshake: one wait state, ack drops after one cycle
		next_s.ack = access;
		next_s.dat = '0;

		// register writes
		if (wr) begin
			case (adr_i)
				ADR_CLOCK_CFG: begin
					wv = wb_merge({24'h0, s.cfg_buf_en ? 8'h40 : 8'h00}, dat_i, sel_i);
					if (sel_i[0]) begin
						next_s.cfg_buf_en = wv[CFG_BUF_EN_BIT];
						next_s.cfg_ext_sel = wv[CFG_EXT_SEL_BIT];
						// reserved codes leave the source unchanged
						if (wv[CFG_SRC_LSB +: 2] == SRC_PRESCALED ||
							wv[CFG_SRC_LSB +: 2] == SRC_SLOW) begin
							next_s.cfg_src = wv[CFG_SRC_LSB +: 2];
						end
						next_s.written = 1'b1;
						// a repeated setup is still applied but flagged
						if (s.written) begin
							next_s.rewritten = 1'b1;
						end
					end
				end
				ADR_HALT_TIME: begin
					wv = wb_merge({16'h0, s.halt_time}, dat_i, sel_i);
					next_s.halt_time = wv[15:0];
				end
				ADR_CONTROL: begin
					wv = wb_merge({31'h0, s.enc_en}, dat_i, sel_i);
					next_s.enc_en = wv[CTRL_ENC_EN_BIT];
					srst = wv[CTRL_SRST_BIT];
				end
				default: begin
					wv = '0;
				end
			endcase
		end

		// register reads
		if (access && !we_i) begin
			case (adr_i)
				ADR_CLOCK_CFG: begin
					rd[CFG_BUF_EN_BIT] = s.cfg_buf_en;
					rd[CFG_EXT_SEL_BIT] = s.cfg_ext_sel;
					rd[CFG_SRC_LSB +: 2] = s.cfg_src;
				end
				ADR_HALT_TIME: begin
					rd[15:0] = s.halt_time;
				end
				ADR_CONTROL: begin
					rd[CTRL_ENC_EN_BIT] = s.enc_en;
				end
				ADR_STATUS: begin
					rd[STAT_HALTED_BIT] = s.halted;
					rd[STAT_WRITTEN_BIT] = s.written;
					rd[STAT_REWRITTEN_BIT] = s.rewritten;
					rd[STAT_SLOW_ACT_BIT] = sw_slow;
				end
				default: begin
					rd = '0;
				end
			endcase
			next_s.dat = rd;
		end

		// ------------------------------------------------------------
		// inactivity timer and halt
		// ------------------------------------------------------------
		// bus accesses count as activity so software is never cut off
		activity = key_event_i || bus_start_i || (encoder_change_i && s.enc_en) ||
			access;
		if (activity) begin
			// a wake in the same cycle as the timeout wins
			next_s.halted = 1'b0;
			next_s.unit_cnt = '0;
			next_s.idle_units = '0;
		end else if (s.halt_time != 16'h0000 && !s.halted) begin
			if (s.unit_cnt == 24'(HALT_UNIT_CYCLES - 1)) begin
				next_s.unit_cnt = '0;
				next_s.idle_units = s.idle_units + 16'h0001;
				// halt is only ever entered from the device's own timer
				if (s.idle_units + 16'h0001 >= s.halt_time) begin
					next_s.halted = 1'b1;
				end
			end else begin
				next_s.unit_cnt = s.unit_cnt + 24'h000001;
			end
		end

		// ------------------------------------------------------------
		// execution clock
		// ------------------------------------------------------------
		// in halt a high phase is finished first, then the clock rests low
		exec_run = !s.halted || s.exec_clk;
		if (exec_run) begin
			if (s.exec_div == EXEC_HALF_CNT) begin
				next_s.exec_div = '0;
				next_s.exec_clk = !s.exec_clk;
				exec_rise = !s.exec_clk;
			end else begin
				next_s.exec_div = s.exec_div + 4'h1;
			end
		end

		// ------------------------------------------------------------
		// prescaled PWM clock
		// ------------------------------------------------------------
		if (exec_rise) begin
			if (s.pre_cnt == PRE_HALF_CNT) begin
				next_s.pre_cnt = '0;
				next_s.pre_clk = !s.pre_clk;
			end else begin
				next_s.pre_cnt = s.pre_cnt + 5'h01;
			end
		end

		// ------------------------------------------------------------
		// pins
		// ------------------------------------------------------------
		// inverting amplifier of the oscillator; weak high when no crystal
		next_s.crystal_out = s.cfg_ext_sel ? 1'b1 : !crystal_in_pin_i;
		next_s.pwm_tb = sw_clk;
		next_s.tb_out = s.cfg_buf_en ? sw_clk : 1'b0;
		next_s.tb_oe_n = !s.cfg_buf_en;
		next_s.pin_release = s.cfg_buf_en;

		// reset command: everything back to defaults, the write still acked
		if (srst) begin
			next_s = st_reset();
			next_s.ack = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= st_reset();
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign ack_o = s.ack;
	assign dat_o = s.dat;
	assign crystal_out_pin_o = s.crystal_out;
	assign buffered_timebase_out_o = s.tb_out;
	assign buffered_timebase_oe_n_o = s.tb_oe_n;
	assign scan8_gpio3_release_o = s.pin_release;
	assign execution_clock_o = s.exec_clk;
	assign pwm_timebase_o = s.pwm_tb;
	assign halted_o = s.halted;

endmodule : kch_clock_halt

// ### include/kch_pkg.sv
// Purpose: shared constants and types for the keypad companion clock and halt block
// Assumes: 25 MHz system clock, classic Wishbone register port with 32-bit data
// Notes:   all counts derive from the printed times and rates below

package kch_pkg;

	// ----------------------------------------------------------------
	// clock rates and dividers
	// ----------------------------------------------------------------
	localparam int unsigned SYS_CLK_HZ = 25000000;
	localparam int unsigned EXEC_CLK_HZ = 2000000;
	// half period of the execution clock, rounded down to whole cycles
	localparam int unsigned EXEC_HALF_CYC = SYS_CLK_HZ / (2 * EXEC_CLK_HZ);
	localparam logic [3:0] EXEC_HALF_CNT = 4'(EXEC_HALF_CYC - 1);
	localparam int unsigned PWM_PRESCALE = 64;
	localparam logic [4:0] PRE_HALF_CNT = 5'(PWM_PRESCALE / 2 - 1);

	// ----------------------------------------------------------------
	// inactivity timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned HALT_UNIT_NS = 1000000;
	localparam int unsigned HALT_UNIT_CYC = HALT_UNIT_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_CLOCK_CFG = 8'h00;
	localparam logic [7:0] ADR_HALT_TIME = 8'h04;
	localparam logic [7:0] ADR_CONTROL = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0C;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CFG_BUF_EN_BIT = 6;
	localparam int unsigned CFG_EXT_SEL_BIT = 3;
	localparam int unsigned CFG_SRC_LSB = 0;
	localparam logic [1:0] SRC_PRESCALED = 2'h0;
	localparam logic [1:0] SRC_SLOW = 2'h3;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [15:0] HALT_TIME_RST = 16'h01F4;
	localparam int unsigned CTRL_ENC_EN_BIT = 0;
	localparam int unsigned CTRL_SRST_BIT = 1;
	localparam int unsigned STAT_HALTED_BIT = 0;
	localparam int unsigned STAT_WRITTEN_BIT = 1;
	localparam int unsigned STAT_REWRITTEN_BIT = 2;
	localparam int unsigned STAT_SLOW_ACT_BIT = 3;

	// ----------------------------------------------------------------
	// timebase switch states
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		SW_RUN = 1'b0,
		SW_PARK = 1'b1
	} kch_sw_e;

endpackage : kch_pkg

// ### logic/kch_tb_switch.sv
// Purpose: glitch-free change-over between the prescaled and the slow timebase
// Assumes: both sources are levels sampled on clk_i
// Notes:   output is parked low between the two sources

module kch_tb_switch
	import kch_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// sources and selection
	input wire logic sel_slow_i,
	input wire logic fast_i,
	input wire logic slow_i,
	// switched timebase
	output logic clk_o,
	output logic slow_active_o
);

	typedef struct packed {
		kch_sw_e state;
		logic cur;
		logic out;
	} kch_sw_s;

	kch_sw_s s;
	kch_sw_s next_s;

	// ----------------------------------------------------------------
	// change-over control
	// ----------------------------------------------------------------
	always_comb begin
		logic cur_lvl;
		logic new_lvl;
		cur_lvl = s.cur ? slow_i : fast_i;
		new_lvl = sel_slow_i ? slow_i : fast_i;
		next_s = s;
		case (s.state)
			SW_RUN: begin
				next_s.out = cur_lvl;
				// leave the old source only in its low phase
				if (sel_slow_i != s.cur && !cur_lvl) begin
					next_s.state = SW_PARK;
					next_s.out = 1'b0;
				end
			end
			SW_PARK: begin
				next_s.out = 1'b0;
				// join the new source in its low phase so its next high is whole
				if (!new_lvl) begin
					next_s.cur = sel_slow_i;
					next_s.state = SW_RUN;
				end
			end
			default: begin
				next_s.state = SW_RUN;
				next_s.cur = 1'b0;
				next_s.out = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s.state <= SW_RUN;
			s.cur <= 1'b0;
			s.out <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign clk_o = s.out;
	assign slow_active_o = s.cur;

endmodule : kch_tb_switch

// ### bench/kch_clock_halt_props.sv
// Purpose: port-level checks on the clock and halt block
// Assumes: one clock domain, synchronous active high reset
// Notes:   halt entry bound is loose since the design allows 1-2 cycles slack
module kch_clock_halt_props
	import kch_pkg::*;
#(
	parameter int unsigned HALT_UNIT_CYCLES = HALT_UNIT_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic key_event_i,
	input wire logic bus_start_i,
	input wire logic buffered_timebase_out_o,
	input wire logic buffered_timebase_oe_n_o,
	input wire logic scan8_gpio3_release_o,
	input wire logic execution_clock_o,
	input wire logic halted_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// encoder left out of activity: it only ever makes this count larger than the design's
	logic [31:0] idle_cnt;
	always_ff @(posedge clk_i) begin
		if (rst_i || cyc_i || key_event_i || bus_start_i) begin
			idle_cnt <= 32'h0;
		end else begin
			idle_cnt <= idle_cnt + 32'h1;
		end
	end
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack one cycle after request");
	a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
	a_pin_release: assert property (buffered_timebase_oe_n_o == !scan8_gpio3_release_o)
		else $error("pin release disagrees with buffer enable");
	a_buf_parked: assert property (buffered_timebase_oe_n_o |-> !buffered_timebase_out_o)
		else $error("buffered output toggles while disabled");
	a_exec_halt_low: assert property (halted_o [*7] |-> !execution_clock_o)
		else $error("execution clock runs in halt");
	a_exec_high_run: assert property (disable iff (rst_i || halted_o || ack_o)
		$rose(execution_clock_o) |-> execution_clock_o [*6] ##1 !execution_clock_o)
		else $error("execution clock high phase not 6 cycles");
	a_wake_key: assert property (halted_o && key_event_i |=> !halted_o)
		else $error("key event did not end halt");
	a_halt_idle: assert property ($rose(halted_o) |-> idle_cnt >= HALT_UNIT_CYCLES - 2)
		else $error("halt entered before idle period");
endmodule : kch_clock_halt_props

// ### bench/kch_host.sv
// Purpose: host model issuing classic Wishbone single cycles
// Assumes: the slave acks every request; the bench timeout ends a hang
// Notes:   counts clock setup writes so repeated setup is visible
module kch_host
	import kch_pkg::*;
(
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] rdat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] wdat_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int setup_writes = 0;
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		wdat_o = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hF;
		wdat_o <= d;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = rdat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		if (w && a == ADR_CLOCK_CFG) setup_writes++;
	endtask : xfer
endmodule : kch_host

// ### bench/kch_clock_halt_tb_top.sv
// Purpose: self-checking bench for clock generation, halt and timebase selection
// Assumes: 25 MHz clock, halt unit shortened to 8 cycles
// Notes:   slow clock is synchronous here so its period is seen exactly
module kch_clock_halt_tb_top
	import kch_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we, ack, slow_in = 1'b0, xin = 1'b0;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q, lfsr = 32'hD0CA;
	logic [2:0] wake = 3'h0;
	logic xout, buf_o, oe_n, rel, exec, pwm, halted;
	int bad_count = 0, checks_done = 0, cyc_cnt = 0;
	kch_clock_halt #(.HALT_UNIT_CYCLES(8)) kch_clock_halt_inst (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
		.dat_o(rdat), .ack_o(ack), .key_event_i(wake[0]), .bus_start_i(wake[1]),
		.encoder_change_i(wake[2]), .ext_slow_clock_in_i(slow_in), .crystal_in_pin_i(xin),
		.crystal_out_pin_o(xout), .buffered_timebase_out_o(buf_o),
		.buffered_timebase_oe_n_o(oe_n), .scan8_gpio3_release_o(rel),
		.execution_clock_o(exec), .pwm_timebase_o(pwm), .halted_o(halted));
	kch_host kch_host_inst (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .wdat_o(wdat));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// slow clock of 40 cycles and the hang limit
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt % 20 == 19) slow_in <= ~slow_in;
		if (cyc_cnt > 60000) begin
			bad_count++;
			wrap_up();
		end
	end
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : step
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		kch_host_inst.xfer(1'b1, a, d, dummy);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		kch_host_inst.xfer(1'b0, a, 32'h0, d);
	endtask : rd
	// rise-to-rise period in clocks: 0 pwm, 1 execution clock, 2 buffered output
	task automatic period(input int w, output logic [31:0] n);
		time t0;
		@(posedge (w == 2 ? buf_o : w == 1 ? exec : pwm));
		t0 = $time;
		@(posedge (w == 2 ? buf_o : w == 1 ? exec : pwm));
		n = 32'(($time - t0) / 40);
	endtask : period
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : settle
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		// ----------------------------------------------------------------
		// reset state and default timebase
		// ----------------------------------------------------------------
		rd(ADR_CLOCK_CFG, q); check(q, 32'(CFG_RST));
		rd(ADR_HALT_TIME, q); check(q, 32'(HALT_TIME_RST));
		rd(ADR_STATUS, q); check(q, 32'h0);
		rd(8'h10, q); check(q, 32'h0);
		check(oe_n, 1'b1);
		period(0, q); check(q, 32'd768);
		period(1, q); check(q, 32'd12);
		// ----------------------------------------------------------------
		// source select, buffer and crystal pin
		// ----------------------------------------------------------------
		wr(ADR_CLOCK_CFG, 32'h49);
		rd(ADR_STATUS, q); check(q[3], 1'b0);
		check(q[2], 1'(kch_host_inst.setup_writes > 1));
		check(rel, 1'b1);
		wr(ADR_CLOCK_CFG, 32'h4B);
		settle(800);
		rd(ADR_STATUS, q); check(q[3:1], 3'h7);
		check(xout, 1'b1);
		period(0, q); check(q, 32'd40);
		period(2, q); check(q, 32'd40);
		wr(ADR_CLOCK_CFG, 32'h43);
		repeat (16) begin
			lfsr = step(lfsr);
			@(posedge clk_i) xin <= lfsr[0];
			settle(1); check(xout, !lfsr[0]);
		end
		// ----------------------------------------------------------------
		// halt entry and every wake source
		// ----------------------------------------------------------------
		wr(ADR_HALT_TIME, 32'h1);
		settle(5); check(halted, 1'b0);
		settle(9); check(halted, 1'b1);
		settle(10); check(exec, 1'b0);
		@(posedge clk_i) wake <= 3'h4;
		@(posedge clk_i) wake <= 3'h0;
		settle(1); check(halted, 1'b1);
		wr(ADR_CONTROL, 32'h1);
		for (int i = 0; i < 3; i++) begin
			settle(14); check(halted, 1'b1);
			@(posedge clk_i) wake <= 3'(1 << i);
			@(posedge clk_i) wake <= 3'h0;
			settle(1); check(halted, 1'b0);
		end
		// ----------------------------------------------------------------
		// reset command and random inactivity periods
		// ----------------------------------------------------------------
		wr(ADR_CONTROL, 32'h2);
		rd(ADR_CLOCK_CFG, q); check(q, 32'h0);
		rd(ADR_STATUS, q); check(q[3:1], 3'h0);
		check(oe_n, 1'b1);
		repeat (8) begin
			lfsr = step(lfsr);
			wr(ADR_HALT_TIME, lfsr);
			rd(ADR_HALT_TIME, q); check(q, {16'h0, lfsr[15:0]});
		end
		wrap_up();
	end
endmodule : kch_clock_halt_tb_top
bind kch_clock_halt kch_clock_halt_props #(.HALT_UNIT_CYCLES(HALT_UNIT_CYCLES)) kch_props_inst (
	.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o, .key_event_i, .bus_start_i,
	.buffered_timebase_out_o, .buffered_timebase_oe_n_o, .scan8_gpio3_release_o,
	.execution_clock_o, .halted_o);
